// File: rlc_pkg.sv
// shared constants and types for the rotate and literal subtract datapath
package rlc_pkg;

  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_ACCUM = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INSTR = 8'h08;
  localparam logic [7:0] OFF_FPTR = 8'h0c;
  localparam logic [7:0] OFF_FDATA = 8'h10;

  // ==========================================================
  // field positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIB = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_BUSY = 3;
  localparam int IN_OP_LSB = 0;
  localparam int IN_DEST = 4;
  localparam int IN_FADDR_LSB = 8;
  localparam int IN_LIT_LSB = 16;

  // ==========================================================
  // reset values and bus constants
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] RD_LOAD = 2'h1;
  localparam logic [1:0] RD_LAST = 2'h2;

  // ==========================================================
  // operations and sequencer states
  typedef enum logic [1:0] {
    rotate_right_via_carry_op,
    rotate_left_via_carry_op,
    literal_minus_accum_op,
    no_op
  } rlc_op_type;

  typedef enum logic [1:0] {E_IDLE, E_FETCH, E_EXEC} rlc_exec_state_type;

endpackage

// File: rlc_file_ram.sv
// file register store: single port, registered read data
`timescale 1ns/1ps
module rlc_file_ram
  import rlc_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  // storage itself has no reset, like a real register file array
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // read returns the old word on a write to the same address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[addr];
    end
  end

endmodule

// File: rlc_alu.sv
// combinational rotate and literal subtract unit
`timescale 1ns/1ps
module rlc_alu
  import rlc_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire rlc_op_type op,
  input wire logic [WIDTH-1:0] fval,
  input wire logic [WIDTH-1:0] wval,
  input wire logic [WIDTH-1:0] lit,
  input wire logic carry_in,
  output logic [WIDTH-1:0] result,
  output logic carry_out,
  output logic nib_out,
  output logic zero_out
);

  logic [WIDTH:0] diff;

  // extra top bit of the difference is the borrow
  assign diff = {1'b0, lit} - {1'b0, wval};

  // result and flag values; the core picks which flags it keeps
  always_comb
  begin
    result = fval;
    carry_out = carry_in;
    nib_out = 1'b0;
    zero_out = 1'b0;
    case (op)
      rotate_right_via_carry_op:
      begin
        result = {carry_in, fval[WIDTH-1:1]}; // see RULE_01
        carry_out = fval[0]; // see RULE_01
      end
      rotate_left_via_carry_op:
      begin
        result = {fval[WIDTH-2:0], carry_in}; // see RULE_07
        carry_out = fval[WIDTH-1]; // see RULE_07
      end
      literal_minus_accum_op:
      begin
        result = diff[WIDTH-1:0]; // see RULE_04
        carry_out = ~diff[WIDTH]; // see RULE_06
        nib_out = (wval[3:0] <= lit[3:0]); // see RULE_06
        zero_out = (diff[WIDTH-1:0] == '0); // see RULE_06
      end
      default:
      begin
        result = fval;
      end
    endcase
  end

endmodule

// File: rlc_core.sv
// bus-facing core: registers, instruction sequencer and file register store
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

// Behaviour
// RULE_01: rotate right: old carry in, bit0 out
// RULE_02: rotate right, dest 0: result to accumulator
// RULE_03: rotate right, dest 1: result back to file
// RULE_04: subtract: literal minus accumulator, two's complement
// RULE_05: subtract result to accumulator, no file write
// RULE_06: subtract sets carry, nibble carry, zero flags
// RULE_07: rotate left: carry in bit0, same destinations
module rlc_core
  import rlc_pkg::*;
#(
  parameter int FILE_DEPTH = 128,
  parameter int FILE_AW = 7
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [7:0] w_value,
  output logic carry_flag,
  output logic busy
);

  // ==========================================================
  // state and wires
  logic [7:0] accum;
  logic carry, nib_carry_flag, zero_flag;
  rlc_op_type cur_op;
  logic cur_dest;
  logic [FILE_AW-1:0] cur_faddr;
  logic [7:0] cur_lit;
  logic [FILE_AW-1:0] fptr;
  rlc_exec_state_type estate;
  logic dp_valid, dp_write, dp_word_ok;
  logic [7:0] dp_off;
  logic [1:0] rd_stage;
  logic addr_take, wr_fire, rd_last, launch, exec_now, rotating;
  logic [31:0] rd_data;
  logic ram_we;
  logic [FILE_AW-1:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] alu_result;
  logic alu_carry, alu_nib, alu_zero;

  // word decode used by every register write
  function automatic logic reg_hit(input logic [7:0] off);
    return wr_fire && dp_word_ok && (dp_off == off);
  endfunction

  // ==========================================================
  // bus handshake
  assign addr_take = hsel && htrans[1] && hready;
  // accesses wait while an instruction runs, so the store has one owner
  assign wr_fire = dp_valid && dp_write && !busy;
  assign rd_last = dp_valid && !dp_write && (rd_stage == RD_LAST);
  assign hreadyout = !dp_valid || wr_fire || rd_last;
  assign hresp = 1'b0;
  assign busy = (estate != E_IDLE);
  assign exec_now = (estate == E_EXEC);
  assign rotating = (cur_op == rotate_right_via_carry_op) || (cur_op == rotate_left_via_carry_op);
  assign launch = reg_hit(OFF_INSTR) && (rlc_op_type'(hwdata[IN_OP_LSB +: 2]) != no_op);
  assign w_value = accum;
  assign carry_flag = carry;

  // address phase capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_word_ok <= 1'b0;
      dp_off <= 8'h00;
    end
    else if (hready)
    begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_word_ok <= (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
      dp_off <= haddr[7:0];
    end
  end

  // read pipeline: address the store, load hrdata, then answer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_stage <= 2'h0;
    else if (rd_last)
      rd_stage <= 2'h0;
    else if (dp_valid && !dp_write && !busy)
      rd_stage <= rd_stage + 2'h1;
  end

  // read data mux; unmapped words read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (dp_off)
      OFF_ACCUM: rd_data[7:0] = accum;
      OFF_STATUS:
      begin
        rd_data[ST_CARRY] = carry;
        rd_data[ST_NIB] = nib_carry_flag;
        rd_data[ST_ZERO] = zero_flag;
        rd_data[ST_BUSY] = busy;
      end
      OFF_INSTR:
      begin
        rd_data[IN_OP_LSB +: 2] = cur_op;
        rd_data[IN_DEST] = cur_dest;
        rd_data[IN_FADDR_LSB +: FILE_AW] = cur_faddr;
        rd_data[IN_LIT_LSB +: 8] = cur_lit;
      end
      OFF_FPTR: rd_data[FILE_AW-1:0] = fptr;
      OFF_FDATA: rd_data[7:0] = ram_rdata;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // registered read data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (dp_valid && !dp_write && (rd_stage == RD_LOAD))
      hrdata <= rd_data;
  end

  // ==========================================================
  // software visible registers
  // instruction word; a write with a real opcode starts it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_op <= no_op;
      cur_dest <= 1'b0;
      cur_faddr <= '0;
      cur_lit <= 8'h00;
    end
    else if (launch)
    begin
      cur_op <= rlc_op_type'(hwdata[IN_OP_LSB +: 2]);
      cur_dest <= hwdata[IN_DEST];
      cur_faddr <= hwdata[IN_FADDR_LSB +: FILE_AW];
      cur_lit <= hwdata[IN_LIT_LSB +: 8];
    end
  end

  // pointer for direct file register access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fptr <= '0;
    else if (reg_hit(OFF_FPTR))
      fptr <= hwdata[FILE_AW-1:0];
  end

  // accumulator: software writes only while idle, so never collides
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      accum <= ACCUM_RST;
    else if (exec_now && (cur_op == literal_minus_accum_op))
      accum <= alu_result; // see RULE_04, RULE_05
    else if (exec_now && rotating && !cur_dest)
      accum <= alu_result; // see RULE_02, RULE_07
    else if (reg_hit(OFF_ACCUM))
      accum <= hwdata[7:0];
  end

  // status flags; rotates touch only carry
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      carry <= FLAG_RST;
      nib_carry_flag <= FLAG_RST;
      zero_flag <= FLAG_RST;
    end
    else if (exec_now)
    begin
      carry <= alu_carry; // see RULE_01, RULE_06, RULE_07
      if (cur_op == literal_minus_accum_op)
      begin
        nib_carry_flag <= alu_nib; // see RULE_06
        zero_flag <= alu_zero; // see RULE_06
      end
    end
    else if (reg_hit(OFF_STATUS))
    begin
      carry <= hwdata[ST_CARRY];
      nib_carry_flag <= hwdata[ST_NIB];
      zero_flag <= hwdata[ST_ZERO];
    end
  end

  // ==========================================================
  // instruction sequencer: fetch operand, then execute
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      estate <= E_IDLE;
    else
    begin
      case (estate)
        E_IDLE: if (launch) estate <= E_FETCH;
        E_FETCH: estate <= E_EXEC;
        E_EXEC: estate <= E_IDLE;
        default: estate <= E_IDLE;
      endcase
    end
  end

  // store port: the sequencer owns it while busy
  always_comb
  begin
    ram_addr = fptr;
    ram_wdata = hwdata[7:0];
    ram_we = reg_hit(OFF_FDATA);
    if (busy)
    begin
      ram_addr = cur_faddr;
      ram_wdata = alu_result;
      ram_we = exec_now && rotating && cur_dest; // see RULE_03, RULE_05
    end
  end

  rlc_file_ram #(
    .DEPTH(FILE_DEPTH),
    .AW(FILE_AW),
    .DW(8)
  ) u_ram (
    .clk(clk),
    .rst(rst),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  rlc_alu #(
    .WIDTH(8)
  ) u_alu (
    .op(cur_op),
    .fval(ram_rdata),
    .wval(accum),
    .lit(cur_lit),
    .carry_in(carry),
    .result(alu_result),
    .carry_out(alu_carry),
    .nib_out(alu_nib),
    .zero_out(alu_zero)
  );

  // ==========================================================
  // checks, with reference values built independently
  wire logic [7:0] exp_rr = {carry, ram_rdata[7:1]};
  wire logic [7:0] exp_rl = {ram_rdata[6:0], carry};
  wire logic [7:0] exp_sub = 8'(cur_lit - accum);
  wire logic exp_le = (accum <= cur_lit);
  wire logic exp_nle = (accum[3:0] <= cur_lit[3:0]);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_run;
    (estate == E_FETCH) ##1 (estate == E_EXEC) ##1 (estate == E_IDLE);
  endsequence
  property p_launch_run;
    launch |=> s_run;
  endproperty
  a_launch_run: assert property (p_launch_run) // every launch runs fetch, execute, then back to idle
    else $error("instruction did not run fetch then execute");

  property p_rule01;
    (exec_now && cur_op == rotate_right_via_carry_op)
      |=> carry == $past(ram_rdata[0]) && $stable(nib_carry_flag) && $stable(zero_flag);
  endproperty
  a_rule01: assert property (p_rule01) // see RULE_01
    else $error("rotate right carry wrong");

  property p_rule02;
    (exec_now && cur_op == rotate_right_via_carry_op && !cur_dest)
      |-> !ram_we ##1 accum == $past(exp_rr);
  endproperty
  a_rule02: assert property (p_rule02) // see RULE_02
    else $error("rotate right to accumulator wrong");

  property p_rule03;
    (exec_now && cur_op == rotate_right_via_carry_op && cur_dest)
      |-> ram_we && ram_wdata == exp_rr && ram_addr == cur_faddr ##1 $stable(accum);
  endproperty
  a_rule03: assert property (p_rule03) // see RULE_03
    else $error("rotate right to file wrong");

  property p_rule04;
    (exec_now && cur_op == literal_minus_accum_op) |=> accum == $past(exp_sub);
  endproperty
  a_rule04: assert property (p_rule04) // see RULE_04
    else $error("literal minus accumulator wrong");

  property p_rule05;
    (estate == E_FETCH && cur_op == literal_minus_accum_op) |-> !ram_we ##1 !ram_we;
  endproperty
  a_rule05: assert property (p_rule05) // see RULE_05
    else $error("subtract wrote the file store");

  property p_rule06;
    (exec_now && cur_op == literal_minus_accum_op)
      |=> carry == $past(exp_le) && nib_carry_flag == $past(exp_nle)
        && zero_flag == (accum == 8'h00);
  endproperty
  a_rule06: assert property (p_rule06) // see RULE_06
    else $error("subtract flags wrong");

  property p_rule07;
    (exec_now && cur_op == rotate_left_via_carry_op)
      |-> (cur_dest ? (ram_we && ram_wdata == exp_rl) : !ram_we)
        ##1 carry == $past(ram_rdata[7]);
  endproperty
  a_rule07: assert property (p_rule07) // see RULE_07
    else $error("rotate left wrong");

endmodule

// File: tb_rotate_and_literal_subtract.sv
// self-checking testbench for the rotate and literal subtract datapath
`timescale 1ns/1ps
module tb_rotate_and_literal_subtract;
  import rlc_pkg::*;

  // ==========================================================
  // signals and design
  logic clk;
  logic rst;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic carry_flag;
  logic busy;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] w_value;
  logic [31:0] q;
  int fails;
  int checks_done;
  // subtract cases: zero, wrap, nibble boundaries, all ones
  logic [7:0] sub_w [6] = '{8'h00, 8'h01, 8'h10, 8'h0f, 8'hff, 8'h05};
  logic [7:0] sub_k [6] = '{8'h00, 8'h00, 8'h0f, 8'h10, 8'hff, 8'hff};

  // single slave, so its ready is the bus ready
  rlc_core u_dut (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .w_value(w_value),
    .carry_flag(carry_flag),
    .busy(busy)
  );

  always #2.5 clk = ~clk;

  // ==========================================================
  // reporting
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // bus master
  // bounded wait; reading right after the edge sees the sampled value
  task wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      $display("BAD t=%0t bus hang", $time);
      complete_run;
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask

  // launch and confirm the sequencer reports busy once the write lands
  task launch(input logic [31:0] ins);
    bus(1'b1, OFF_INSTR, ins);
    #1;
    chk({31'h0, busy}, 32'h1, "busy");
  endtask

  // ==========================================================
  // operation tasks
  task rot(input logic op, input logic d, input logic [7:0] f, input logic ci);
    logic [7:0] r;
    logic co;
    r = op ? {f[6:0], ci} : {ci, f[7:1]};
    co = op ? f[7] : f[0];
    bus(1'b1, OFF_ACCUM, 32'h5a);
    bus(1'b1, OFF_FPTR, 32'h45);
    bus(1'b1, OFF_FDATA, {24'h0, f});
    bus(1'b1, OFF_STATUS, {31'h0, ci});
    launch({16'h0, 1'b0, 7'h45, 3'h0, d, 3'h0, op});
    bus(1'b0, OFF_ACCUM, 32'h0);
    chk(q, d ? 32'h5a : {24'h0, r}, "rot accum");
    chk({24'h0, w_value}, d ? 32'h5a : {24'h0, r}, "w port");
    bus(1'b0, OFF_FDATA, 32'h0);
    chk(q, {24'h0, d ? r : f}, "rot file");
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q, {31'h0, co}, "rot status");
    chk({31'h0, carry_flag}, {31'h0, co}, "carry port");
  endtask

  // dest bit set on purpose: the difference must still go to the accumulator
  task sub(input logic [7:0] w, input logic [7:0] k);
    logic [7:0] r;
    r = k - w;
    bus(1'b1, OFF_ACCUM, {24'h0, w});
    bus(1'b1, OFF_FPTR, 32'h11);
    bus(1'b1, OFF_FDATA, 32'ha5);
    bus(1'b1, OFF_STATUS, 32'h7);
    launch({8'h0, k, 1'b0, 7'h11, 3'h0, 1'b1, 2'h0, 2'h2});
    bus(1'b0, OFF_ACCUM, 32'h0);
    chk(q, {24'h0, r}, "sub accum");
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q, {29'h0, r == 8'h0, w[3:0] <= k[3:0], w <= k}, "sub flags");
    bus(1'b0, OFF_FDATA, 32'h0);
    chk(q, 32'ha5, "sub file");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    fails = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset state on ports and registers
    chk({21'h0, w_value, carry_flag, busy, hresp}, 32'h0, "reset ports");
    bus(1'b0, OFF_ACCUM, 32'h0);
    chk(q, 32'h0, "reset accum");
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h0, "reset status");
    $display("test reset done");
    // both rotate directions, both destinations, carry in each way; carry out each way on rotate right, only 1 on rotate left
    for (int o = 0; o < 2; o++)
      for (int d = 0; d < 2; d++)
        for (int i = 0; i < 2; i++)
          rot(o[0], d[0], i ? 8'h81 : 8'he6, i[0] ^ d[0]);
    $display("test rotate done");
    for (int i = 0; i < 6; i++)
      sub(sub_w[i], sub_k[i]);
    $display("test subtract done");
    // reserved operation code launches nothing; unmapped offset reads zero
    bus(1'b1, OFF_ACCUM, 32'h33);
    bus(1'b1, OFF_INSTR, 32'h3);
    bus(1'b0, OFF_ACCUM, 32'h0);
    chk(q, 32'h33, "op3 accum");
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0, "unmapped");
    $display("test refusal done");
    complete_run;
  end
endmodule
